// file: inc/pcei_params.svh
// Constants for the power controller emulation override and interrupt block
`ifndef PCEI_PARAMS_SVH
`define PCEI_PARAMS_SVH

// ****************************************
// Geometry
// ****************************************
`define PCEI_NUM_MOD        41
`define PCEI_LO_BITS        32
`define PCEI_HI_BITS        9
`define PCEI_AW             12

// ****************************************
// Register byte offsets
// ****************************************
`define PCEI_OFF_REEVAL     12'h018
`define PCEI_OFF_MPEND_LO   12'h040
`define PCEI_OFF_MPEND_HI   12'h044
`define PCEI_OFF_MCLR_LO    12'h050
`define PCEI_OFF_MCLR_HI    12'h054
`define PCEI_OFF_DPEND      12'h060
`define PCEI_OFF_DCLR       12'h068
`define PCEI_OFF_DSTAT      12'h200
`define PCEI_OFF_DCTL       12'h300
`define PCEI_OFF_MSTAT      12'h800
`define PCEI_OFF_MCTL       12'hA00
`define PCEI_BANK_SPAN      12'h0A4

// ****************************************
// Field positions
// ****************************************
`define PCEI_REEVAL_BIT     0
`define PCEI_DPEND_BIT      0
`define PCEI_DCTL_NEXT_BIT  0
`define PCEI_DCTL_STIE_BIT  9
`define PCEI_DSTAT_ON_BIT   0
`define PCEI_DSTAT_FLAG_BIT 11
`define PCEI_MCTL_NEXT_LSB  0
`define PCEI_MCTL_NEXT_MSB  1
`define PCEI_MCTL_LREL_BIT  8
`define PCEI_MCTL_RSTIE_BIT 9
`define PCEI_MCTL_STIE_BIT  10
`define PCEI_MSTAT_LRST_BIT 8
`define PCEI_MSTAT_RFLG_BIT 10
`define PCEI_MSTAT_SFLG_BIT 11

// ****************************************
// Reset values
// ****************************************
`define PCEI_MSTATE_RST     2'h2
`define PCEI_DNEXT_RST      1'b1

`endif

// file: inc/pcei_pkg.sv
// Types shared by the power controller emulation override and interrupt block
`include "pcei_params.svh"
package pcei_pkg;

  // Module states; bit 1 = module reset released, bit 0 = clock on
  typedef enum logic [1:0] {
    reset_clock_off_state = 2'h0,
    reset_clock_on_state  = 2'h1,
    mod_disable           = 2'h2,
    mod_enable            = 2'h3
  } pcei_mstate_e;

  // Domain sequencer, Gray along off -> wait -> on
  typedef enum logic [1:0] {
    dom_off      = 2'h0,
    dom_wait_ack = 2'h1,
    dom_on       = 2'h3
  } pcei_dom_e;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`PCEI_AW-1:0]     paddr;
    logic [31:0]             pwdata;
  } pcei_apb_req_s;

  typedef struct packed {
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } pcei_apb_rsp_s;

  typedef struct packed {
    logic                    force_domain_on;
    logic [`PCEI_NUM_MOD-1:0] inhibit_sleep;
    logic [`PCEI_NUM_MOD-1:0] force_module_enabled;
    logic [`PCEI_NUM_MOD-1:0] assert_reset;
    logic [`PCEI_NUM_MOD-1:0] wait_reset;
    logic [`PCEI_NUM_MOD-1:0] block_reset;
  } pcei_emu_cmd_s;

endpackage

// file: logic/pcei_emu_irq_ctrl.sv
// Emulation override and interrupt logic of the power and sleep controller
//
// What this block does
// R1 - Inhibit-sleep blocks software moving domain out of on, module out of enabled.
// R2 - Force-power drives the domain on whatever software programmed.
// R3 - Force-active puts domain on and module enabled.
// R4 - Assert-reset drives the selected module's local reset active.
// R5 - Wait-reset keeps local reset active after software asks for release.
// R6 - Block-reset ignores software changes to local reset and module reset.
// R7 - Forced power-up completes only after host applies power and acknowledges.
// R8 - When overrides drop, move at once toward software-programmed next states.
// R9 - One interrupt output, raised by domain, module, local reset or external events.
// R10 - Domain state-event enable gates interrupts for emulation domain changes.
// R11 - Module state-event enable gates interrupts for emulation module changes.
// R12 - Module reset-event enable gates interrupts for emulation local reset changes.
// R13 - State flag set on inhibited exit from enabled or force-active on non-enabled.
// R14 - Reset flag set by assert over release, wait-reset, or blocked change.
// R15 - Summary pending bits per module and for domain, with detailed status flags.
// R16 - Write-only clear bits remove module and domain pending status.
// R17 - Re-evaluate rechecks pending bits and raises interrupt again if any still set.
// R18 - External power-control pending event is always enabled.
// R19 - Interrupt is sent as soon as an enabled event becomes active.
// R20 - Software sets re-evaluate before leaving its service routine.
// R21 - Host reads pending, reads status, services, clears, then re-evaluates.
// R22 - Software sets enables and unmasks the interrupt before expecting it.
// R23 - Next-state encoding: 0 reset clock off, 1 reset clock on, 2 disable, 3 enable.
// R24 - Writing 1 to re-evaluate triggers it; writing 0 does nothing.
// R25 - Module clear 1 clears pending bit and status flags; 0 does nothing.
// R26 - Pending split: low word modules 0-31, high word modules 32-40 in bits 8:0.
// R27 - Status and pending stay set until software clears them.
`timescale 1ns/1ps
`default_nettype none
`include "pcei_params.svh"
module pcei_emu_irq_ctrl (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Register bus
  input  wire pcei_pkg::pcei_apb_req_s apb_req,
  output var  pcei_pkg::pcei_apb_rsp_s apb_rsp,
  // Emulation controller
  input  wire pcei_pkg::pcei_emu_cmd_s emu_cmd,
  // Host power handshake and external event
  input  wire logic                    host_pwr_ack,
  input  wire logic                    ext_pwr_pending,
  output logic                         host_pwr_req,
  // Power, clock and reset controls
  output logic                         domain_on,
  output logic [`PCEI_NUM_MOD-1:0]     module_clk_en,
  output logic [`PCEI_NUM_MOD-1:0]     module_rst_n,
  output logic [`PCEI_NUM_MOD-1:0]     module_lrst_n,
  // Interrupt to the processor
  output logic                         power_ctrl_irq
);
  import pcei_pkg::*;

  localparam int N = `PCEI_NUM_MOD;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic in_bank(input logic [`PCEI_AW-1:0] a, input logic [`PCEI_AW-1:0] base);
    in_bank = (a >= base) && (a < base + `PCEI_BANK_SPAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [5:0] bank_idx(input logic [`PCEI_AW-1:0] a, input logic [`PCEI_AW-1:0] base);
    logic [`PCEI_AW-1:0] d;
    d = a - base;
    bank_idx = d[7:2];
  endfunction

  logic                  acc_wr;
  logic                  wr_reeval;
  logic                  wr_dclr;
  logic                  wr_dctl;
  logic                  wr_mctl_any;
  logic [5:0]            wr_idx;
  logic [N-1:0]          mclr;

  assign acc_wr      = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_reeval   = acc_wr && (apb_req.paddr == `PCEI_OFF_REEVAL)
                       && apb_req.pwdata[`PCEI_REEVAL_BIT]; // R24
  assign wr_dclr     = acc_wr && (apb_req.paddr == `PCEI_OFF_DCLR)
                       && apb_req.pwdata[`PCEI_DPEND_BIT]; // R16
  assign wr_dctl     = acc_wr && (apb_req.paddr == `PCEI_OFF_DCTL);
  assign wr_mctl_any = acc_wr && in_bank(apb_req.paddr, `PCEI_OFF_MCTL);
  assign wr_idx      = bank_idx(apb_req.paddr, `PCEI_OFF_MCTL);
  // R16 R26
  assign mclr = {(acc_wr && apb_req.paddr == `PCEI_OFF_MCLR_HI) ? apb_req.pwdata[`PCEI_HI_BITS-1:0]
                                                                : {`PCEI_HI_BITS{1'b0}},
                 (acc_wr && apb_req.paddr == `PCEI_OFF_MCLR_LO) ? apb_req.pwdata : 32'h0};

  // ****************************************
  // Domain control and sequencing
  // ****************************************
  pcei_dom_e dom_q;
  pcei_dom_e dom_d;
  logic      dom_next_q;
  logic      dom_stie_q;
  logic      dom_flag_q;
  logic      dom_pend_q;
  logic      dom_alter_q;
  logic      ext_q;
  logic      forced;
  logic      dom_want_on;
  logic      dom_alter;
  logic      dom_evt;
  logic      ext_evt;
  logic      dom_pend_set;

  assign forced      = emu_cmd.force_domain_on || (|emu_cmd.force_module_enabled); // R2 R3
  assign dom_want_on = forced || dom_next_q
                       || ((|emu_cmd.inhibit_sleep) && dom_q == dom_on); // R1
  // Domain held or forced on against software's wish
  assign dom_alter    = dom_want_on && !dom_next_q;
  assign dom_evt      = dom_alter && !dom_alter_q;
  assign ext_evt      = ext_pwr_pending && !ext_q;
  assign dom_pend_set = (dom_evt && dom_stie_q) || ext_evt; // R10 R18

  always_comb
  begin
    dom_d = dom_q;
    case (dom_q)
      dom_off:
        if (forced)
          dom_d = dom_wait_ack;
        else if (dom_next_q)
          dom_d = dom_on;
      // A forced power-up hangs here until the host acknowledges or the domain is no longer wanted on
      dom_wait_ack:
        if (host_pwr_ack)
          dom_d = dom_on; // R7
        else if (!dom_want_on)
          dom_d = dom_off; // R8
      dom_on:
        if (!dom_want_on)
          dom_d = dom_off; // R8
      default:
        dom_d = dom_off;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dom_q <= dom_on;
    else
      dom_q <= dom_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dom_next_q <= `PCEI_DNEXT_RST;
      dom_stie_q <= 1'b0;
    end
    else if (wr_dctl)
    begin
      dom_next_q <= apb_req.pwdata[`PCEI_DCTL_NEXT_BIT];
      dom_stie_q <= apb_req.pwdata[`PCEI_DCTL_STIE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dom_alter_q <= 1'b0;
      ext_q       <= 1'b0;
    end
    else
    begin
      dom_alter_q <= dom_alter;
      ext_q       <= ext_pwr_pending;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dom_flag_q <= 1'b0;
      dom_pend_q <= 1'b0;
    end
    else
    begin
      dom_flag_q <= dom_evt || (dom_flag_q && !wr_dclr); // R27
      dom_pend_q <= dom_pend_set || (dom_pend_q && !wr_dclr); // R15 R16
    end
  end

  assign domain_on    = (dom_q == dom_on);
  assign host_pwr_req = (dom_q == dom_wait_ack); // R7

  // ****************************************
  // Per-module state, local reset and events
  // ****************************************
  wire logic [N-1:0] pend_vec;
  wire logic [N-1:0] pend_set_vec;
  wire logic [31:0]  mctl_word  [N];
  wire logic [31:0]  mstat_word [N];

  for (genvar i = 0; i < N; i++)
  begin : g_mod
    logic       wr_this;
    logic       blk_try;
    logic [1:0] next_q;
    logic       lrel_q;
    logic       stie_q;
    logic       rstie_q;
    logic [1:0] state_q;
    logic [1:0] target;
    logic       lrst_n_q;
    logic       lrst_n_d;
    logic       sflag_q;
    logic       rflag_q;
    logic       pend_q;
    logic       scond_q;
    logic [1:0] rcond_q;
    logic       scond;
    logic [1:0] rcond;
    logic       s_evt;
    logic       r_evt;
    logic       p_set;

    assign wr_this = wr_mctl_any && (wr_idx == 6'(i));
    // Software tries to flip the local reset while it is blocked
    assign blk_try = wr_this && emu_cmd.block_reset[i]
                     && (apb_req.pwdata[`PCEI_MCTL_LREL_BIT] != lrel_q); // R14

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        next_q  <= `PCEI_MSTATE_RST;
        lrel_q  <= 1'b0;
        stie_q  <= 1'b0;
        rstie_q <= 1'b0;
      end
      else if (wr_this)
      begin
        next_q  <= apb_req.pwdata[`PCEI_MCTL_NEXT_MSB:`PCEI_MCTL_NEXT_LSB]; // R23
        stie_q  <= apb_req.pwdata[`PCEI_MCTL_STIE_BIT];
        rstie_q <= apb_req.pwdata[`PCEI_MCTL_RSTIE_BIT];
        if (!emu_cmd.block_reset[i])
          lrel_q <= apb_req.pwdata[`PCEI_MCTL_LREL_BIT]; // R6
      end
    end

    always_comb
    begin
      target = next_q; // R8
      if (emu_cmd.inhibit_sleep[i] && state_q == mod_enable)
        target = mod_enable; // R1
      if (emu_cmd.block_reset[i])
        target[1] = state_q[1]; // R6
      if (emu_cmd.force_module_enabled[i])
        target = mod_enable; // R3
    end

    // A clocked state waits until its domain is powered
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        state_q <= `PCEI_MSTATE_RST;
      else if (target != state_q && (!target[0] || domain_on))
        state_q <= target; // R7
    end

    always_comb
    begin
      if (emu_cmd.assert_reset[i])
        lrst_n_d = 1'b0; // R4
      else if (emu_cmd.block_reset[i])
        lrst_n_d = lrst_n_q; // R6
      else if (!lrel_q)
        lrst_n_d = 1'b0;
      else if (emu_cmd.wait_reset[i])
        lrst_n_d = lrst_n_q; // R5
      else
        lrst_n_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        lrst_n_q <= 1'b0;
      else
        lrst_n_q <= lrst_n_d;
    end

    assign scond = (emu_cmd.inhibit_sleep[i] && state_q == mod_enable && next_q != mod_enable)
                   || (emu_cmd.force_module_enabled[i] && state_q != mod_enable); // R13
    // Wait-reset is its own event, even under assert-reset
    assign rcond = {emu_cmd.wait_reset[i], emu_cmd.assert_reset[i] && lrel_q}; // R14
    assign s_evt = scond && !scond_q;
    assign r_evt = (|(rcond & ~rcond_q)) || blk_try;
    assign p_set = (s_evt && stie_q) || (r_evt && rstie_q); // R11 R12

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        scond_q <= 1'b0;
        rcond_q <= 2'h0;
      end
      else
      begin
        scond_q <= scond;
        rcond_q <= rcond;
      end
    end

    // Sticky until cleared; a set in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sflag_q <= 1'b0;
        rflag_q <= 1'b0;
        pend_q  <= 1'b0;
      end
      else
      begin
        sflag_q <= s_evt || (sflag_q && !mclr[i]); // R25 R27
        rflag_q <= r_evt || (rflag_q && !mclr[i]); // R25 R27
        pend_q  <= p_set || (pend_q && !mclr[i]); // R15 R25
      end
    end

    assign module_clk_en[i] = state_q[0] && domain_on;
    assign module_rst_n[i]  = state_q[1];
    assign module_lrst_n[i] = lrst_n_q;
    assign pend_vec[i]      = pend_q;
    assign pend_set_vec[i]  = p_set;

    assign mctl_word[i]  = {21'h0, stie_q, rstie_q, lrel_q, 6'h0, next_q};
    assign mstat_word[i] = {20'h0, sflag_q, rflag_q, 1'b0, lrst_n_q, 6'h0, state_q};
  end

  // ****************************************
  // Interrupt
  // ****************************************
  logic irq_q;

  // One-cycle pulse per new enabled event, or per re-evaluate while anything pends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= (|pend_set_vec) || dom_pend_set // R9 R19
               || (wr_reeval && ((|pend_vec) || dom_pend_q)); // R17
  end

  assign power_ctrl_irq = irq_q;

  // ****************************************
  // Register read path
  // ****************************************
  logic [31:0] rdata_d;
  logic        mapped;
  logic [31:0] rdata_q;

  always_comb
  begin
    rdata_d = 32'h0;
    mapped  = 1'b1;
    if (in_bank(apb_req.paddr, `PCEI_OFF_MSTAT))
      rdata_d = mstat_word[bank_idx(apb_req.paddr, `PCEI_OFF_MSTAT)];
    else if (in_bank(apb_req.paddr, `PCEI_OFF_MCTL))
      rdata_d = mctl_word[bank_idx(apb_req.paddr, `PCEI_OFF_MCTL)];
    else
      case (apb_req.paddr)
        `PCEI_OFF_MPEND_LO: rdata_d = pend_vec[`PCEI_LO_BITS-1:0]; // R26
        `PCEI_OFF_MPEND_HI: rdata_d = {23'h0, pend_vec[N-1:`PCEI_LO_BITS]}; // R26
        `PCEI_OFF_DPEND:    rdata_d = {31'h0, dom_pend_q};
        `PCEI_OFF_DSTAT:    rdata_d = {20'h0, dom_flag_q, 10'h0, domain_on};
        `PCEI_OFF_DCTL:     rdata_d = {22'h0, dom_stie_q, 8'h0, dom_next_q};
        // Write-only registers read as zero
        `PCEI_OFF_REEVAL,
        `PCEI_OFF_MCLR_LO,
        `PCEI_OFF_MCLR_HI,
        `PCEI_OFF_DCLR:     rdata_d = 32'h0;
        default:            mapped  = 1'b0;
      endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h0;
    else if (apb_req.psel && !apb_req.penable)
      rdata_q <= (apb_req.pwrite || !mapped) ? 32'h0 : rdata_d;
  end

  assign apb_rsp.prdata  = rdata_q;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

endmodule
`default_nettype wire

// file: tb/pcei_asserts.sv
// Port checker of the emulation override and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "pcei_params.svh"
module pcei_chk (
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // Register bus
  input wire pcei_pkg::pcei_apb_req_s  apb_req,
  input wire pcei_pkg::pcei_apb_rsp_s  apb_rsp,
  // Emulation and host
  input wire pcei_pkg::pcei_emu_cmd_s  emu_cmd,
  input wire logic                     host_pwr_ack,
  input wire logic                     ext_pwr_pending,
  input wire logic                     host_pwr_req,
  // Controls and interrupt
  input wire logic                     domain_on,
  input wire logic [`PCEI_NUM_MOD-1:0] module_clk_en,
  input wire logic [`PCEI_NUM_MOD-1:0] module_rst_n,
  input wire logic [`PCEI_NUM_MOD-1:0] module_lrst_n,
  input wire logic                     power_ctrl_irq
);
  import pcei_pkg::*;
  // Force-active and assert-reset outrank block, so they are left out of the frozen set
  wire logic [`PCEI_NUM_MOD-1:0] blk = emu_cmd.block_reset & ~emu_cmd.assert_reset
                                       & ~emu_cmd.force_module_enabled;
  wire logic [`PCEI_NUM_MOD-1:0] run = module_clk_en & module_rst_n;
  wire logic [`PCEI_NUM_MOD-1:0] asr = emu_cmd.assert_reset & ~emu_cmd.wait_reset;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Override and interrupt properties
  // ****************************************
  chk_inhibit_hold: assert property (|(emu_cmd.inhibit_sleep & run) |=>
    (run | ~$past(emu_cmd.inhibit_sleep & run)) == '1) else $error("inhibited module left enable");
  chk_force_req: assert property (emu_cmd.force_domain_on && !domain_on |=> host_pwr_req || domain_on)
    else $error("forced power-up not requested");
  chk_wait_ack: assert property (host_pwr_req && !host_pwr_ack && !$past(host_pwr_ack) && !domain_on
    |=> !domain_on) else $error("domain on without acknowledge");
  chk_ack_on: assert property (host_pwr_req && host_pwr_ack && emu_cmd.force_domain_on
    |-> ##[1:2] domain_on) else $error("acknowledged power-up not finished");
  chk_force_act: assert property ((|emu_cmd.force_module_enabled) && domain_on |=>
    (run | ~$past(emu_cmd.force_module_enabled)) == '1) else $error("forced module not enabled");
  chk_lrst_forced: assert property (|asr |=> (module_lrst_n & $past(asr)) == '0)
    else $error("local reset not asserted");
  chk_wait_release: assert property (|emu_cmd.wait_reset |=>
    (module_lrst_n & ~$past(module_lrst_n) & $past(emu_cmd.wait_reset)) == '0) else $error("released in wait");
  chk_block_freeze: assert property (|blk |=> (((module_lrst_n ^ $past(module_lrst_n))
    | (module_rst_n ^ $past(module_rst_n))) & $past(blk) & $past(blk, 2)) == '0) else $error("blocked reset moved");
  chk_ext_irq: assert property ($rose(ext_pwr_pending) |=> power_ctrl_irq)
    else $error("no interrupt for external event");
endmodule

bind pcei_emu_irq_ctrl pcei_chk u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .emu_cmd(emu_cmd),
  .host_pwr_ack(host_pwr_ack), .ext_pwr_pending(ext_pwr_pending), .host_pwr_req(host_pwr_req),
  .domain_on(domain_on), .module_clk_en(module_clk_en), .module_rst_n(module_rst_n),
  .module_lrst_n(module_lrst_n), .power_ctrl_irq(power_ctrl_irq)
);
`default_nettype wire

// file: tb/pcei_host_model.sv
// Host side model: power-up acknowledge and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pcei_host_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Power handshake
  input  wire logic       host_pwr_req,
  input  wire logic [7:0] ack_dly,
  output logic            host_pwr_ack,
  // Interrupt controller
  input  wire logic       power_ctrl_irq,
  input  wire logic       irq_unmask,
  output logic [7:0]      irq_cnt
);
  logic [7:0] wait_q;
  // ****************************************
  // Power applied some cycles after request
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q       <= 8'h00;
      host_pwr_ack <= 1'b0;
    end
    else
    begin
      host_pwr_ack <= host_pwr_req && !host_pwr_ack && wait_q == ack_dly;
      wait_q       <= (host_pwr_req && wait_q != ack_dly) ? wait_q + 8'h01 : 8'h00;
    end
  end
  // Masked pulses are lost, as in a real interrupt controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_cnt <= 8'h00;
    else if (power_ctrl_irq && irq_unmask)
      irq_cnt <= irq_cnt + 8'h01;
  end
endmodule
`default_nettype wire

// file: tb/tb_power_ctrl_emu_override_irq.sv
// Self-checking bench of the emulation override and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "pcei_params.svh"
module tb_power_ctrl_emu_override_irq;
  import pcei_pkg::*;
  logic                     pclk, presetn, ack, ext, pwr_req, dom_on, irq, unmask, err;
  pcei_apb_req_s            req;
  pcei_apb_rsp_s            rsp;
  pcei_emu_cmd_s            emu;
  logic [`PCEI_NUM_MOD-1:0] clk_en, rst_n, lrst_n;
  logic [7:0]               irq_cnt;
  logic [31:0]              rdat;
  int                       mismatches = 0;
  int                       n_compared = 0;
  int                       exp_irq = 0;
  int                       cyc = 0;

  pcei_emu_irq_ctrl dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .emu_cmd(emu), .host_pwr_ack(ack),
    .ext_pwr_pending(ext), .host_pwr_req(pwr_req), .domain_on(dom_on), .module_clk_en(clk_en),
    .module_rst_n(rst_n), .module_lrst_n(lrst_n), .power_ctrl_irq(irq)
  );
  pcei_host_model host (
    .pclk(pclk), .presetn(presetn), .host_pwr_req(pwr_req), .ack_dly(8'h08), .host_pwr_ack(ack),
    .power_ctrl_irq(irq), .irq_unmask(unmask), .irq_cnt(irq_cnt)
  );

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  function automatic logic [11:0] mctl(input int n);
    return `PCEI_OFF_MCTL + 12'(4 * n);
  endfunction
  function automatic logic [11:0] mstat(input int n);
    return `PCEI_OFF_MSTAT + 12'(4 * n);
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [40:0] got, input logic [40:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    settle();
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, 41'(rdat), 41'(e));
  endtask
  task automatic irqc(input int d);
    settle();
    exp_irq += d;
    chk("irq count", 41'(irq_cnt), 41'(exp_irq));
  endtask

  // A hang counts as a mismatch
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    req = '0;
    emu = '0;
    ext = 1'b0;
    unmask = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("domain on", 41'(dom_on), 41'h1);
    chk("clk en", clk_en, '0);
    chk("rst", rst_n, '1);
    chk("lrst", lrst_n, '0);
    rdc("mctl0", mctl(0), 32'h2);
    rdc("dctl", `PCEI_OFF_DCTL, 32'h1);
    rdc("mclr", `PCEI_OFF_MCLR_LO, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("slverr", 41'(err), 41'h1);
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      wr(mctl(9), 32'(c));
      chk("clk9", 41'(clk_en[9]), 41'(c & 1));
      chk("rst9", 41'(rst_n[9]), 41'(c >> 1));
    end
    $display("test next codes done");
    wr(mctl(5), 32'h402);
    emu.force_module_enabled <= 41'h20;
    irqc(1);
    chk("clk5", 41'(clk_en[5]), 41'h1);
    rdc("mstat5", mstat(5), 32'h803);
    rdc("pend lo", `PCEI_OFF_MPEND_LO, 32'h20);
    emu.force_module_enabled <= '0;
    settle();
    chk("clk5 off", 41'(clk_en[5]), 41'h0);
    wr(`PCEI_OFF_MCLR_LO, 32'h0);
    rdc("mstat5 kept", mstat(5), 32'h802);
    wr(`PCEI_OFF_MCLR_LO, 32'h20);
    rdc("pend lo clr", `PCEI_OFF_MPEND_LO, 32'h0);
    rdc("mstat5 clr", mstat(5), 32'h002);
    wr(mctl(40), 32'h402);
    emu.force_module_enabled <= 41'h10200000000;
    irqc(1);
    rdc("pend hi", `PCEI_OFF_MPEND_HI, 32'h100);
    rdc("mstat33", mstat(33), 32'h803);
    emu.force_module_enabled <= '0;
    wr(`PCEI_OFF_MCLR_HI, 32'h102);
    rdc("pend hi clr", `PCEI_OFF_MPEND_HI, 32'h0);
    rdc("mstat33 clr", mstat(33), 32'h002);
    $display("test module state done");
    wr(mctl(2), 32'h302);
    chk("lrst2 rel", 41'(lrst_n[2]), 41'h1);
    emu.assert_reset[2] <= 1'b1;
    irqc(1);
    chk("lrst2 on", 41'(lrst_n[2]), 41'h0);
    rdc("mstat2", mstat(2), 32'h402);
    wr(`PCEI_OFF_MCLR_LO, 32'h4);
    emu.wait_reset[2] <= 1'b1;
    irqc(1);
    emu.assert_reset[2] <= 1'b0;
    settle();
    chk("lrst2 wait", 41'(lrst_n[2]), 41'h0);
    emu.wait_reset[2] <= 1'b0;
    settle();
    chk("lrst2 free", 41'(lrst_n[2]), 41'h1);
    wr(`PCEI_OFF_MCLR_LO, 32'h4);
    emu.block_reset[2] <= 1'b1;
    wr(mctl(2), 32'h201);
    chk("lrst2 blk", 41'(lrst_n[2]), 41'h1);
    chk("rst2 blk", 41'(rst_n[2]), 41'h1);
    rdc("pend blk", `PCEI_OFF_MPEND_LO, 32'h4);
    irqc(1);
    emu.block_reset[2] <= 1'b0;
    settle();
    chk("rst2 unblk", 41'(rst_n[2]), 41'h0);
    wr(`PCEI_OFF_MCLR_LO, 32'h4);
    $display("test local reset done");
    wr(mctl(7), 32'h403);
    chk("clk7", 41'(clk_en[7]), 41'h1);
    emu.inhibit_sleep[7] <= 1'b1;
    wr(mctl(7), 32'h402);
    chk("clk7 kept", 41'(clk_en[7]), 41'h1);
    rdc("mstat7", mstat(7), 32'h803);
    irqc(1);
    emu.inhibit_sleep[7] <= 1'b0;
    settle();
    chk("clk7 off", 41'(clk_en[7]), 41'h0);
    wr(`PCEI_OFF_MCLR_LO, 32'h80);
    $display("test inhibit done");
    wr(`PCEI_OFF_DCTL, 32'h200);
    chk("dom off", 41'(dom_on), 41'h0);
    emu.force_domain_on <= 1'b1;
    settle();
    chk("pwr req", 41'(pwr_req), 41'h1);
    chk("dom wait", 41'(dom_on), 41'h0);
    repeat (12) @(posedge pclk);
    chk("dom forced", 41'(dom_on), 41'h1);
    irqc(1);
    rdc("dpend", `PCEI_OFF_DPEND, 32'h1);
    rdc("dstat", `PCEI_OFF_DSTAT, 32'h801);
    wr(`PCEI_OFF_DCLR, 32'h1);
    rdc("dpend clr", `PCEI_OFF_DPEND, 32'h0);
    rdc("dstat clr", `PCEI_OFF_DSTAT, 32'h001);
    emu.force_domain_on <= 1'b0;
    settle();
    chk("dom drop", 41'(dom_on), 41'h0);
    wr(`PCEI_OFF_DCTL, 32'h1);
    $display("test domain done");
    ext <= 1'b1;
    irqc(1);
    rdc("dpend ext", `PCEI_OFF_DPEND, 32'h1);
    wr(`PCEI_OFF_REEVAL, 32'h0);
    irqc(0);
    wr(`PCEI_OFF_REEVAL, 32'h1);
    irqc(1);
    unmask <= 1'b0;
    wr(`PCEI_OFF_REEVAL, 32'h1);
    irqc(0);
    unmask <= 1'b1;
    ext <= 1'b0;
    wr(`PCEI_OFF_DCLR, 32'h1);
    wr(`PCEI_OFF_REEVAL, 32'h1);
    irqc(0);
    $display("test reevaluate done");
    finish_test();
  end
endmodule
`default_nettype wire
